// *** inc/supply_io_pkg.sv ***
package supply_io_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IO = 8'h04;
  localparam logic [7:0] REG_INT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_FLAGS = 8'h10;

  // control word fields
  localparam int CTL_XCVR = 0;
  localparam int CTL_AUX_EN = 1;
  localparam int CTL_AUX_3V3 = 2;
  localparam int CTL_PASS = 3;
  localparam int CTL_UV_INT = 4;
  localparam int CTL_LOAD_RES = 5;
  localparam int CTL_DBG_EXIT = 6;
  localparam int CTL_MON_LSB = 8;
  localparam int CTL_SAFE_OVR = 12;
  localparam int CTL_SAFE_LSB = 13;

  // io and interrupt word fields
  localparam int IO_LINES = 4;
  localparam int IO_CYCLIC = 8;
  localparam int INT_PULSE = 8;
  localparam int INT_DUR_LSB = 9;

  // status word fields
  localparam int ST_DEBUG = 0;
  localparam int ST_XCVR = 1;
  localparam int ST_AUX = 2;
  localparam int ST_IO_LSB = 4;
  localparam int ST_PIN_LSB = 8;
  localparam int ST_SAFE_LSB = 13;

  // sticky flags
  localparam int NFLAG = 5;
  localparam int FL_AUX_UV = 0;
  localparam int FL_AUX_OC = 1;
  localparam int FL_UPPER_UV = 2;
  localparam int FL_DBG_EXIT = 3;
  localparam int FL_FAULT = 4;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int INT_PULSE_BASE_US = 10;
  localparam int INT_PULSE_BASE_CYC = INT_PULSE_BASE_US * CLK_MHZ;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {IO_INPUT, IO_HIGH_SIDE, IO_LOW_SIDE, IO_HIGH_Z} io_mode_e;
  typedef io_mode_e [IO_LINES-1:0] io_mode_arr_t;
  typedef enum logic [2:0] {
    MON_SUPPLY, MON_BATTERY_SENSE, MON_IO0, MON_IO1, MON_REFERENCE, MON_DIE_TEMP,
    MON_CURRENT_COPY
  } mon_src_e;

  typedef struct packed {
    logic aux_uv;
    logic aux_oc;
    logic upper_uv;
    logic lower_uv;
    logic dbg_window;
    logic fault;
    logic [IO_LINES-1:0] io_in;
    logic [2:0] safe_res;
  } pin_in_s;

  localparam int PIN_W = $bits(pin_in_s);

  typedef struct packed {
    pin_in_s s1;
    pin_in_s s2;
    pin_in_s s3;
    pin_in_s pin;
    pin_in_s pin_prev;
    logic init_prev;
    logic xcvr_en;
    logic aux_en;
    logic aux_3v3;
    logic pass_en;
    logic uv_int_mode;
    logic load_res;
    mon_src_e mon_sel;
    logic safe_ovr;
    logic [2:0] safe_sw;
    io_mode_arr_t io_mode;
    logic cyclic;
    logic [NFLAG-1:0] int_mask;
    logic int_pulse;
    logic [1:0] int_dur;
    logic [NFLAG-1:0] flags;
    logic debug;
    logic [15:0] pulse_cnt;
    logic int_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

endpackage

// *** rtl/supply_io_ctrl.sv ***
// Overview of operation
// - transceiver supply regulator off after power-up, on by host write or by debug detection
// - debug detection turns the transceiver supply regulator on by default
// - auxiliary regulator target 5.0 V or 3.3 V chosen by a control bit
// - auxiliary regulator off after power-up, switched on only by host write
// - auxiliary low voltage or overcurrent disables it, flags it, may interrupt
// - control bit picks reset or interrupt at upper undervoltage threshold
// - interrupt option in normal mode: interrupt upper, reset only at lower
// - pass transistor path enabled and controlled only by host write
// - each io line set as input, high side, low side or high impedance
// - all io lines come up as inputs
// - in low power io outputs stay controllable, overload protection off
// - cyclic sensing: io 0 set as input or high side drives the supply, io 1 to 3 are wake inputs
// - monitor source chosen from seven sources by a host write
// - control bit connects load resistor for the current copy source
// - transceiver supply off: monitor selection writes ignored, output grounded
// - debug detected only leaving init reset with debug pin in window
// - debug stops watchdog supervision and is readable in status
// - debug pin leaving window ends debug and restarts watchdog
// - host command ends debug even while the debug pin stays in window
// - safe behaviour from pin resistor or host, host wins, resistor not in debug
// - interrupt line held low or pulsed low, style and length by host
// - safe output driven low on a fault input event, held until its sticky flag is cleared
`timescale 1ns/1ps
`default_nettype none

module supply_io_ctrl
  import supply_io_pkg::*;
#(
  parameter int PULSE_BASE_CYC = INT_PULSE_BASE_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparators and pins, asynchronous
  input wire pin_in_s pins,
  // mode logic, same clock
  input wire logic init_reset,
  input wire logic normal_mode,
  input wire logic low_power_operation,
  // regulators
  output logic xcvr_reg_en,
  output logic auxiliary_regulator_output_en,
  output logic auxiliary_regulator_3v3,
  output logic pass_transistor_base_en,
  output logic uv_reset_req,
  // configurable io lines
  output logic [IO_LINES-1:0] high_side_driver_en,
  output logic [IO_LINES-1:0] low_side_driver_en,
  output logic io_overload_prot_en,
  // analog monitor
  output mon_src_e analog_monitor_output_sel,
  output logic analog_monitor_output_gnd,
  output logic analog_monitor_output_load_en,
  // debug, watchdog, safe and interrupt
  output logic debug_active,
  output logic watchdog_active,
  output logic [2:0] safe_mode_sel,
  output logic safe_o,
  output logic safe_oe,
  output logic int_n
);

  // ************************************************************
  // state
  // ************************************************************
  state_s q;
  state_s d;
  localparam logic [15:0] PULSE_BASE = 16'(PULSE_BASE_CYC);

  logic acc;
  logic wr;
  logic mapped;
  logic [31:0] rd_word;
  logic [NFLAG-1:0] ev;
  logic [NFLAG-1:0] clr;
  logic dbg_detect;
  logic upper_to_int;
  io_mode_e eff_mode [IO_LINES];

  // ************************************************************
  // effective io modes
  // ************************************************************
  always_comb begin
    for (int i = 0; i < IO_LINES; i++) begin
      eff_mode[i] = q.io_mode[i];
      if (q.cyclic) begin
        if (i == 0) begin
          // io 0 must switch the sense supply, so an input setting becomes high side
          eff_mode[i] = (q.io_mode[i] == IO_INPUT) ? IO_HIGH_SIDE : q.io_mode[i];
        end else begin
          eff_mode[i] = IO_INPUT;
        end
      end
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    acc = psel && penable;
    wr = acc && pwrite && q.pready;
    mapped = (paddr == REG_CTRL) || (paddr == REG_IO) || (paddr == REG_INT) ||
             (paddr == REG_STAT) || (paddr == REG_FLAGS);

    // three-stage sync; a change counts once stages two and three agree
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pin = pin_in_s'((q.s2 & ~(q.s2 ^ q.s3)) | (q.pin & (q.s2 ^ q.s3)));
    d.pin_prev = q.pin;
    d.init_prev = init_reset;

    // events are edges of the filtered levels
    upper_to_int = q.uv_int_mode && normal_mode;
    ev = '0;
    ev[FL_AUX_UV] = q.pin.aux_uv && !q.pin_prev.aux_uv;
    ev[FL_AUX_OC] = q.pin.aux_oc && !q.pin_prev.aux_oc;
    ev[FL_UPPER_UV] = upper_to_int && q.pin.upper_uv && !q.pin_prev.upper_uv;
    ev[FL_FAULT] = q.pin.fault && !q.pin_prev.fault;

    // apb read data, captured in the first access cycle
    rd_word = '0;
    case (paddr)
      REG_CTRL: begin
        rd_word[CTL_XCVR] = q.xcvr_en;
        rd_word[CTL_AUX_EN] = q.aux_en;
        rd_word[CTL_AUX_3V3] = q.aux_3v3;
        rd_word[CTL_PASS] = q.pass_en;
        rd_word[CTL_UV_INT] = q.uv_int_mode;
        rd_word[CTL_LOAD_RES] = q.load_res;
        rd_word[CTL_MON_LSB +: 3] = q.mon_sel;
        rd_word[CTL_SAFE_OVR] = q.safe_ovr;
        rd_word[CTL_SAFE_LSB +: 3] = q.safe_sw;
      end
      REG_IO: begin
        rd_word[2*IO_LINES-1:0] = q.io_mode;
        rd_word[IO_CYCLIC] = q.cyclic;
      end
      REG_INT: begin
        rd_word[NFLAG-1:0] = q.int_mask;
        rd_word[INT_PULSE] = q.int_pulse;
        rd_word[INT_DUR_LSB +: 2] = q.int_dur;
      end
      REG_STAT: begin
        rd_word[ST_DEBUG] = q.debug;
        rd_word[ST_XCVR] = q.xcvr_en;
        rd_word[ST_AUX] = q.aux_en;
        rd_word[ST_IO_LSB +: IO_LINES] = q.pin.io_in;
        rd_word[ST_PIN_LSB +: 5] = {q.pin.dbg_window, q.pin.lower_uv, q.pin.upper_uv,
                                    q.pin.aux_oc, q.pin.aux_uv};
        rd_word[ST_SAFE_LSB +: 3] = safe_mode_sel;
      end
      REG_FLAGS: begin
        rd_word[NFLAG-1:0] = q.flags;
      end
      default: begin
        rd_word = '0;
      end
    endcase

    // two-cycle access: pready rises one cycle into the access phase
    if (acc && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !mapped;
      d.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end

    // register writes take effect at the edge that completes the access
    clr = '0;
    if (wr && mapped) begin
      case (paddr)
        REG_CTRL: begin
          d.xcvr_en = pwdata[CTL_XCVR];
          d.aux_en = pwdata[CTL_AUX_EN];
          d.aux_3v3 = pwdata[CTL_AUX_3V3];
          d.pass_en = pwdata[CTL_PASS];
          d.uv_int_mode = pwdata[CTL_UV_INT];
          d.load_res = pwdata[CTL_LOAD_RES];
          // the monitor buffer runs from the transceiver supply, selection writes are ignored while off
          if (q.xcvr_en) begin
            d.mon_sel = mon_src_e'(pwdata[CTL_MON_LSB +: 3]);
          end
          d.safe_ovr = pwdata[CTL_SAFE_OVR];
          d.safe_sw = pwdata[CTL_SAFE_LSB +: 3];
          if (pwdata[CTL_DBG_EXIT]) begin
            d.debug = 1'b0;
          end
        end
        REG_IO: begin
          d.io_mode = io_mode_arr_t'(pwdata[2*IO_LINES-1:0]);
          d.cyclic = pwdata[IO_CYCLIC];
        end
        REG_INT: begin
          d.int_mask = pwdata[NFLAG-1:0];
          d.int_pulse = pwdata[INT_PULSE];
          d.int_dur = pwdata[INT_DUR_LSB +: 2];
        end
        REG_FLAGS: begin
          clr = pwdata[NFLAG-1:0];
        end
        default: begin
          clr = '0;
        end
      endcase
    end

    // auxiliary faults drop the regulator even against a write in the same cycle
    if (q.pin.aux_uv || q.pin.aux_oc) begin
      d.aux_en = 1'b0;
    end

    // debug: detected only on release of init reset, ended by pin or command
    dbg_detect = q.init_prev && !init_reset && q.pin.dbg_window;
    if (q.debug && !q.pin.dbg_window) begin
      d.debug = 1'b0;
      ev[FL_DBG_EXIT] = 1'b1;
    end
    if (wr && (paddr == REG_CTRL) && pwdata[CTL_DBG_EXIT] && q.debug) begin
      ev[FL_DBG_EXIT] = 1'b1;
    end
    if (dbg_detect) begin
      d.debug = 1'b1;
      d.xcvr_en = 1'b1;
    end

    // sticky flags: a new event beats a clear in the same cycle
    d.flags = (q.flags & ~clr) | ev;

    // interrupt line, level or pulse; pulse length doubles per step
    if (q.int_pulse) begin
      if (|(ev & q.int_mask)) begin
        d.pulse_cnt = PULSE_BASE << q.int_dur;
      end else if (q.pulse_cnt != 16'h0000) begin
        d.pulse_cnt = q.pulse_cnt - 16'h0001;
      end
      d.int_n = !((|(ev & q.int_mask)) || (q.pulse_cnt > 16'h0001));
    end else begin
      d.pulse_cnt = 16'h0000;
      d.int_n = !(|(d.flags & q.int_mask));
    end

    // init reset restores defaults; debug detection waits for its release
    if (init_reset) begin
      d.xcvr_en = 1'b0;
      d.aux_en = 1'b0;
      d.aux_3v3 = 1'b0;
      d.pass_en = 1'b0;
      d.uv_int_mode = 1'b0;
      d.load_res = 1'b0;
      d.mon_sel = MON_SUPPLY;
      d.safe_ovr = 1'b0;
      d.safe_sw = 3'h0;
      d.io_mode = io_mode_arr_t'({IO_LINES{IO_INPUT}});
      d.cyclic = 1'b0;
      d.int_mask = '0;
      d.int_pulse = 1'b0;
      d.int_dur = 2'h0;
      d.flags = '0;
      d.debug = 1'b0;
      d.pulse_cnt = 16'h0000;
      d.int_n = 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0; // all defaults are zero except int_n high; zero io modes are inputs
      q.int_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;

  assign xcvr_reg_en = q.xcvr_en;
  assign auxiliary_regulator_output_en = q.aux_en;
  assign auxiliary_regulator_3v3 = q.aux_3v3;
  assign pass_transistor_base_en = q.pass_en;
  // upper threshold resets unless the interrupt option applies in normal mode
  assign uv_reset_req = q.pin.lower_uv ||
                        (q.pin.upper_uv && !(q.uv_int_mode && normal_mode));

  always_comb begin
    for (int i = 0; i < IO_LINES; i++) begin
      high_side_driver_en[i] = (eff_mode[i] == IO_HIGH_SIDE);
      low_side_driver_en[i] = (eff_mode[i] == IO_LOW_SIDE);
    end
  end
  // drivers stay controllable in low power, only the protection drops
  assign io_overload_prot_en = !low_power_operation;

  assign analog_monitor_output_sel = q.mon_sel;
  assign analog_monitor_output_gnd = !q.xcvr_en;
  assign analog_monitor_output_load_en = q.load_res && (q.mon_sel == MON_CURRENT_COPY);

  assign debug_active = q.debug;
  assign watchdog_active = !q.debug;
  // the command wins; the resistor reading is meaningless while debug holds the pin
  assign safe_mode_sel = q.safe_ovr ? q.safe_sw : (q.debug ? 3'h0 : q.pin.safe_res);
  assign safe_o = 1'b0;
  assign safe_oe = q.flags[FL_FAULT];
  assign int_n = q.int_n;

endmodule // supply_io_ctrl

`default_nettype wire

// *** sim/supply_io_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// host side of the register bus
// ****
module supply_io_host
  import supply_io_pkg::*;
(
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hFF;
    pwdata = 32'h0;
  end
  // no wait limit here, a hang is cut by the bench timeout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // monitor readings are junk until the transceiver supply is up
  task automatic supply_ok(output logic ok);
    logic [31:0] r;
    logic e;
    xfer(1'b0, REG_STAT, 32'h0, r, e);
    ok = r[ST_XCVR];
  endtask
endmodule // supply_io_host
`default_nettype wire

// *** sim/supply_io_ctrl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module supply_io_checker
  import supply_io_pkg::*;
(
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic pready,
  // mode
  input wire logic init_reset,
  input wire logic low_power_operation,
  // outputs
  input wire logic xcvr_reg_en,
  input wire logic auxiliary_regulator_output_en,
  input wire logic pass_transistor_base_en,
  input wire logic io_overload_prot_en,
  input wire mon_src_e analog_monitor_output_sel,
  input wire logic analog_monitor_output_gnd,
  input wire logic analog_monitor_output_load_en,
  input wire logic debug_active,
  input wire logic watchdog_active,
  input wire logic safe_o,
  input wire logic safe_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_xcvr;
    $rose(xcvr_reg_en) |-> debug_active || $past(pwrite && pready);
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("xcvr on");
  property p_aux;
    $rose(auxiliary_regulator_output_en) |-> $past(pwrite && pready);
  endproperty
  a_aux: assert property (p_aux) else $error("aux on");
  property p_pass;
    $rose(pass_transistor_base_en) |-> $past(pwrite && pready);
  endproperty
  a_pass: assert property (p_pass) else $error("pass on");
  property p_prot;
    io_overload_prot_en == !low_power_operation;
  endproperty
  a_prot: assert property (p_prot) else $error("prot");
  property p_load;
    analog_monitor_output_load_en |-> analog_monitor_output_sel == MON_CURRENT_COPY;
  endproperty
  a_load: assert property (p_load) else $error("load");
  property p_gnd;
    analog_monitor_output_gnd == !xcvr_reg_en;
  endproperty
  a_gnd: assert property (p_gnd) else $error("gnd");
  property p_wdog;
    watchdog_active != debug_active;
  endproperty
  a_wdog: assert property (p_wdog) else $error("wdog");
  property p_safe;
    safe_oe |-> !safe_o;
  endproperty
  a_safe: assert property (p_safe) else $error("safe");
  // one cycle of grace, the clear is registered
  property p_init;
    init_reset && $past(init_reset) |-> !(auxiliary_regulator_output_en ||
      pass_transistor_base_en || debug_active);
  endproperty
  a_init: assert property (p_init) else $error("init");
endmodule // supply_io_checker
bind supply_io_ctrl supply_io_checker supply_io_checker_i (.*);
`default_nettype wire

// *** sim/sbc_supply_io_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_supply_io_control_bench import supply_io_pkg::*;;
  // ****
  // harness
  // ****
  localparam int PB = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  pin_in_s pins = '0;
  logic init_reset = 1'b0;
  logic normal_mode = 1'b0;
  logic low_power_operation = 1'b0;
  logic xcvr_reg_en, auxiliary_regulator_output_en, auxiliary_regulator_3v3;
  logic pass_transistor_base_en, uv_reset_req, io_overload_prot_en;
  logic [IO_LINES-1:0] high_side_driver_en, low_side_driver_en;
  mon_src_e analog_monitor_output_sel;
  logic analog_monitor_output_gnd, analog_monitor_output_load_en;
  logic debug_active, watchdog_active, safe_o, safe_oe, int_n;
  logic [2:0] safe_mode_sel;
  int mismatches = 0;
  int tests_run = 0;
  always #2 pclk = ~pclk;
  // short pulse base keeps the run brief
  supply_io_ctrl #(.PULSE_BASE_CYC(PB)) supply_io_ctrl_i (.*);
  supply_io_host supply_io_host_i (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    supply_io_host_i.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    supply_io_host_i.xfer(1'b0, a, 32'h0, r, e);
    chk(n, r, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reg;
    logic [31:0] r;
    logic e;
    logic ok;
    rdc("ctrl", REG_CTRL, 32'h0);
    rdc("io", REG_IO, 32'h0);
    wr(REG_CTRL, 32'h300);
    rdc("mon", REG_CTRL, 32'h0);
    @(negedge pclk);
    chk("gnd", 32'(analog_monitor_output_gnd), 32'h1);
    wr(REG_CTRL, 32'h1);
    supply_io_host_i.supply_ok(ok);
    chk("ok", 32'(ok), 32'h1);
    for (int m = 0; m < 7; m++) begin
      wr(REG_CTRL, 32'h2F | (m << CTL_MON_LSB));
      @(negedge pclk);
      chk("sel", 32'(analog_monitor_output_sel), m);
      chk("load", 32'(analog_monitor_output_load_en), 32'(m == 6));
    end
    chk("reg", 32'({auxiliary_regulator_output_en, auxiliary_regulator_3v3,
      pass_transistor_base_en}), 32'h7);
    wr(REG_CTRL, 32'h3);
    @(negedge pclk);
    chk("reg", 32'({auxiliary_regulator_output_en, auxiliary_regulator_3v3,
      pass_transistor_base_en}), 32'h4);
    supply_io_host_i.xfer(1'b0, 8'h14, 32'h0, r, e);
    chk("err", 32'(e), 32'h1);
    $display("t_reg done");
  endtask
  task automatic t_io;
    for (int m = 0; m < 4; m++) begin
      wr(REG_IO, 32'h55 * m);
      @(negedge pclk);
      chk("hs", 32'(high_side_driver_en), (m == 1) ? 32'hF : 32'h0);
      chk("ls", 32'(low_side_driver_en), (m == 2) ? 32'hF : 32'h0);
    end
    wr(REG_IO, 32'h100);
    @(negedge pclk);
    chk("cyc", 32'({high_side_driver_en, low_side_driver_en}), 32'h10);
    wr(REG_IO, 32'h55);
    low_power_operation <= 1'b1;
    @(negedge pclk);
    chk("lp", 32'({high_side_driver_en, io_overload_prot_en}), 32'h1E);
    $display("t_io done");
  endtask
  task automatic t_aux;
    int n;
    wr(REG_INT, 32'h1);
    wr(REG_CTRL, 32'h3);
    pins.aux_uv <= 1'b1;
    cyc(8);
    @(negedge pclk);
    chk("aux", 32'({auxiliary_regulator_output_en, int_n}), 32'h0);
    rdc("flags", REG_FLAGS, 32'h1);
    pins.aux_uv <= 1'b0;
    cyc(8);
    wr(REG_FLAGS, 32'h1);
    cyc(2);
    @(negedge pclk);
    chk("int", 32'(int_n), 32'h1);
    wr(REG_INT, 32'h102);
    pins.aux_oc <= 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge pclk);
      if (int_n === 1'b0) n++;
    end
    chk("pulse", n, PB);
    $display("t_aux done");
  endtask
  task automatic t_uv;
    wr(REG_CTRL, 32'h10);
    normal_mode <= 1'b1;
    pins.aux_oc <= 1'b0;
    pins.upper_uv <= 1'b1;
    cyc(8);
    @(negedge pclk);
    chk("rst", 32'(uv_reset_req), 32'h0);
    rdc("flags", REG_FLAGS, 32'h6);
    pins.lower_uv <= 1'b1;
    cyc(8);
    @(negedge pclk);
    chk("rst", 32'(uv_reset_req), 32'h1);
    wr(REG_CTRL, 32'h0);
    pins.lower_uv <= 1'b0;
    cyc(8);
    @(negedge pclk);
    chk("rst", 32'(uv_reset_req), 32'h1);
    $display("t_uv done");
  endtask
  task automatic t_safe;
    cyc(1);
    pins.upper_uv <= 1'b0;
    pins.safe_res <= 3'h5;
    pins.fault <= 1'b1;
    cyc(8);
    @(negedge pclk);
    chk("safe", 32'({safe_oe, safe_o, safe_mode_sel}), 32'h15);
    wr(REG_CTRL, 32'h7000);
    pins.fault <= 1'b0;
    @(negedge pclk);
    chk("ovr", 32'(safe_mode_sel), 32'h3);
    $display("t_safe done");
  endtask
  task automatic t_debug;
    cyc(1);
    pins.dbg_window <= 1'b1;
    cyc(8);
    @(negedge pclk);
    chk("dbg", 32'(debug_active), 32'h0);
    cyc(1);
    init_reset <= 1'b1;
    cyc(8);
    rdc("init", REG_CTRL, 32'h0);
    rdc("init", REG_IO, 32'h0);
    init_reset <= 1'b0;
    cyc(4);
    @(negedge pclk);
    chk("dbg", 32'({debug_active, watchdog_active, xcvr_reg_en, safe_oe}), 32'hA);
    rdc("stat", REG_STAT, 32'h1003);
    pins.dbg_window <= 1'b0;
    cyc(8);
    @(negedge pclk);
    chk("exit", 32'({debug_active, watchdog_active}), 32'h1);
    rdc("flags", REG_FLAGS, 32'h8);
    pins.dbg_window <= 1'b1;
    init_reset <= 1'b1;
    cyc(8);
    init_reset <= 1'b0;
    cyc(6);
    @(negedge pclk);
    chk("dbg", 32'(debug_active), 32'h1);
    wr(REG_CTRL, 32'h40);
    @(negedge pclk);
    chk("cmd", 32'(debug_active), 32'h0);
    $display("t_debug done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reg;
    t_io;
    t_aux;
    t_uv;
    t_safe;
    t_debug;
    end_of_test;
  end
  // tests need about 300 cycles, so 25000 means a hang
  initial begin
    #100000;
    mismatches++;
    end_of_test;
  end
endmodule // sbc_supply_io_control_bench
`default_nettype wire
